// ==== capture_defs.svh ====
// constants for the input capture unit: offsets, fields, reset values
// Operation
// R1 - copy 16-bit time base on event
// R2 - mode codes select capture edge
// R3 - each capture sets capture flag
// R4 - flag stays set until software clears
// R5 - new capture overwrites old value
// R6 - prescaler zero when off or not capture
// R7 - any reset clears prescaler
// R8 - prescale change keeps prescaler count
// R9 - software zeroes control before new prescale
// R10 - mode change may raise false flag
// R11 - software masks and clears flag on change
// R12 - software sets pin as input
// R13 - port latch write can trigger capture
// R14 - time base in timer or sync mode
// R15 - time base not clocked from oscillator
// R16 - time base halts in sleep on internal clock
// R17 - external clock keeps capture alive in sleep
// R18 - two-stage pin synchroniser before edge detect
// R19 - other modes never capture or flag
`ifndef CAPTURE_DEFS_SVH
`define CAPTURE_DEFS_SVH
`define OFS_CONTROL      8'h00
`define OFS_CAPTURE_LOW  8'h04
`define OFS_CAPTURE_HIGH 8'h08
`define OFS_FLAG_STATUS  8'h0C
`define OFS_FLAG_CLEAR   8'h10
`define OFS_FLAG_ENABLE  8'h14
`define OFS_PIN_CONTROL  8'h18
`define CONTROL_RESET    8'h00
`define MODE_FALL        4'h4
`define MODE_RISE        4'h5
`define MODE_RISE4       4'h6
`define MODE_RISE16      4'h7
`define PRESCALE_LAST4   4'h3
`define PRESCALE_LAST16  4'hF
`define FLAG_CAPTURE     0
`define PIN_DIR_BIT      0
`define PIN_LATCH_BIT    1
`define PIN_RESET        2'h1
`endif

// ==== capture_pkg.sv ====
// types for the input capture unit
package capture_pkg;
  typedef enum logic [1:0] {
    edge_fall_type_e,
    edge_rise_type_e,
    edge_none_type_e
  } edge_sel_type;
endpackage

// ==== edge_event_detect.sv ====
// synchroniser and edge detector for the capture pin
`timescale 1ns/1ps
module edge_event_detect
  import capture_pkg::*;
(
  input  wire logic clock,      // system clock
  input  wire logic rst,        // sync reset, active high
  input  wire logic pin_level,  // raw pin level after direction mux
  output logic      rise_pulse, // one-cycle rising edge
  output logic      fall_pulse  // one-cycle falling edge
);
  logic sync_first_reg;
  logic sync_second_reg;
  logic last_level_reg;

  // three flops: two synchroniser stages, the first read only by the second, then the last level
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sync_first_reg  <= 1'b0;
      sync_second_reg <= 1'b0;
      last_level_reg  <= 1'b0;
    end
    else
    begin
      sync_first_reg  <= pin_level;       // R18
      sync_second_reg <= sync_first_reg;  // R18
      last_level_reg  <= sync_second_reg;
    end
  end

  assign rise_pulse = sync_second_reg & ~last_level_reg;
  assign fall_pulse = ~sync_second_reg & last_level_reg;

  chk_single_rise: assert property (@(posedge clock) disable iff (rst)
    rise_pulse |=> !rise_pulse) else $error("rise pulse longer than one cycle"); // R18
  chk_edge_delay: assert property (@(posedge clock) disable iff (rst)
    rise_pulse |-> $past(pin_level, 2) && !$past(pin_level, 3)) else $error("rise not from pin"); // R18
endmodule

// ==== input_capture_unit.sv ====
// input capture unit with axi4-lite register slave
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "capture_defs.svh"
module input_capture_unit
  import capture_pkg::*;
(
  input  wire logic        clock,          // system clock, 100 MHz
  input  wire logic        rst,            // sync reset, active high
  input  wire logic [15:0] time_base,      // shared time base counter
  input  wire logic        pin_in,         // capture pin input level
  output logic             pin_out,        // capture pin output level
  output logic             pin_oe,         // capture pin drive enable
  output logic             irq,            // level interrupt
  input  wire logic [7:0]  s_axi_awaddr,   // write address
  input  wire logic        s_axi_awvalid,  // write address valid
  output logic             s_axi_awready,  // write address ready
  input  wire logic [31:0] s_axi_wdata,    // write data
  input  wire logic [3:0]  s_axi_wstrb,    // write strobes
  input  wire logic        s_axi_wvalid,   // write data valid
  output logic             s_axi_wready,   // write data ready
  output logic [1:0]       s_axi_bresp,    // write response
  output logic             s_axi_bvalid,   // write response valid
  input  wire logic        s_axi_bready,   // write response ready
  input  wire logic [7:0]  s_axi_araddr,   // read address
  input  wire logic        s_axi_arvalid,  // read address valid
  output logic             s_axi_arready,  // read address ready
  output logic [31:0]      s_axi_rdata,    // read data
  output logic [1:0]       s_axi_rresp,    // read response
  output logic             s_axi_rvalid,   // read data valid
  input  wire logic        s_axi_rready    // read data ready
);
  logic [7:0]  control_reg;
  logic [15:0] capture_value_reg;
  logic [3:0]  prescale_reg;
  logic        capture_event_flag_reg;
  logic        capture_irq_enable_reg;
  logic [1:0]  pin_ctl_reg;
  logic [7:0]  aw_addr_reg;
  logic        aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_held_reg;
  logic        irq_reg;
  logic        rise_pulse;
  logic        fall_pulse;
  logic        pin_level;
  logic        edge_hit;
  logic        capture_fire;
  logic        wr_go;
  logic        flag_clear;
  logic [3:0]  unit_mode_field;
  edge_sel_type edge_sel;

  // decode of a capture mode code to the edge it watches
  function automatic edge_sel_type mode_edge(input logic [3:0] mode);
    case (mode)
      `MODE_FALL:   mode_edge = edge_fall_type_e;
      `MODE_RISE,
      `MODE_RISE4,
      `MODE_RISE16: mode_edge = edge_rise_type_e;
      default:      mode_edge = edge_none_type_e;
    endcase
  endfunction

  assign unit_mode_field = control_reg[3:0];
  assign edge_sel        = mode_edge(unit_mode_field);

  // pin drives its latch when direction bit is low; latch writes then loop back
  assign pin_level = pin_ctl_reg[`PIN_DIR_BIT] ? pin_in : pin_ctl_reg[`PIN_LATCH_BIT]; // R13
  assign pin_out   = pin_ctl_reg[`PIN_LATCH_BIT];
  assign pin_oe    = ~pin_ctl_reg[`PIN_DIR_BIT];

  edge_event_detect u_edge (
    .clock      (clock),
    .rst        (rst),
    .pin_level  (pin_level),
    .rise_pulse (rise_pulse),
    .fall_pulse (fall_pulse)
  );

  // qualifying edge for the selected mode
  always_comb
  begin
    unique case (edge_sel)
      edge_fall_type_e: edge_hit = fall_pulse;  // R2
      edge_rise_type_e: edge_hit = rise_pulse;  // R2
      edge_none_type_e: edge_hit = 1'b0;        // R19
    endcase
  end

  // capture fires on every edge, or when the prescaler wraps
  always_comb
  begin
    unique case (unit_mode_field)
      `MODE_RISE4:  capture_fire = edge_hit && ({2'b00, prescale_reg[1:0]} == `PRESCALE_LAST4); // R2
      `MODE_RISE16: capture_fire = edge_hit && (prescale_reg == `PRESCALE_LAST16);     // R2
      default:      capture_fire = edge_hit;
    endcase
  end

  // prescaler; a direct prescale change keeps the count, so a false capture may follow
  always_ff @(posedge clock)
  begin
    if (rst)
      prescale_reg <= 4'h0;                       // R7
    else if (edge_sel != edge_rise_type_e || unit_mode_field == `MODE_RISE)
      prescale_reg <= 4'h0;                       // R6
    else if (edge_hit)
      prescale_reg <= prescale_reg + 4'h1;        // R8 R10
  end

  // capture register; overwrites freely, never blocks
  // the time base is copied as it stands, frozen or running, so sleep needs no special case
  always_ff @(posedge clock)
  begin
    if (rst)
      capture_value_reg <= 16'h0000;
    else if (capture_fire)
      capture_value_reg <= time_base;             // R1 R5 R16 R17
  end

  // sticky flag; a new capture beats a clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (rst)
      capture_event_flag_reg <= 1'b0;
    else if (capture_fire)
      capture_event_flag_reg <= 1'b1;             // R3
    else if (flag_clear)
      capture_event_flag_reg <= 1'b0;             // R4
  end

  // level interrupt, registered
  always_ff @(posedge clock)
  begin
    if (rst)
      irq_reg <= 1'b0;
    else
      irq_reg <= capture_event_flag_reg & capture_irq_enable_reg;
  end
  assign irq = irq_reg;

  // write channel: address and data taken in either order
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
  assign wr_go         = aw_held_reg & w_held_reg;
  assign flag_clear    = wr_go && aw_addr_reg == `OFS_FLAG_CLEAR && w_strb_reg[0]
                         && w_data_reg[`FLAG_CAPTURE];

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_bresp = 2'b00;

  // writable registers; only the low byte lane holds state
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      control_reg            <= `CONTROL_RESET;
      capture_irq_enable_reg <= 1'b0;
      pin_ctl_reg            <= `PIN_RESET;
    end
    else if (wr_go && w_strb_reg[0])
    begin
      unique case (aw_addr_reg)
        `OFS_CONTROL:     control_reg            <= {2'b00, w_data_reg[5:0]};
        `OFS_FLAG_ENABLE: capture_irq_enable_reg <= w_data_reg[`FLAG_CAPTURE];
        `OFS_PIN_CONTROL: pin_ctl_reg            <= w_data_reg[1:0];
        default:          ;
      endcase
    end
  end

  // read channel, answer one cycle after the address is taken
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      unique case ({s_axi_araddr[7:2], 2'b00})
        `OFS_CONTROL:      s_axi_rdata <= {24'h000000, control_reg};
        `OFS_CAPTURE_LOW:  s_axi_rdata <= {24'h000000, capture_value_reg[7:0]};
        `OFS_CAPTURE_HIGH: s_axi_rdata <= {24'h000000, capture_value_reg[15:8]};
        `OFS_FLAG_STATUS:  s_axi_rdata <= {31'h00000000, capture_event_flag_reg};
        `OFS_FLAG_ENABLE:  s_axi_rdata <= {31'h00000000, capture_irq_enable_reg};
        `OFS_PIN_CONTROL:  s_axi_rdata <= {30'h00000000, pin_ctl_reg};
        default:           s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  assign s_axi_rresp = 2'b00;

  // checks
  chk_capture_copy: assert property (@(posedge clock) disable iff (rst)
    capture_fire |=> capture_value_reg == $past(time_base)) else $error("capture value wrong"); // R1
  chk_capture_flag: assert property (@(posedge clock) disable iff (rst)
    capture_fire |=> capture_event_flag_reg) else $error("flag not set on capture"); // R3
  chk_flag_sticky: assert property (@(posedge clock) disable iff (rst)
    capture_event_flag_reg && !flag_clear |=> capture_event_flag_reg) else $error("flag dropped"); // R4
  chk_prescale_idle: assert property (@(posedge clock) disable iff (rst)
    edge_sel == edge_none_type_e |=> prescale_reg == 4'h0) else $error("prescaler not held"); // R6
  chk_no_capture: assert property (@(posedge clock) disable iff (rst)
    edge_sel == edge_none_type_e |=> $stable(capture_value_reg)) else $error("capture outside mode"); // R19
  chk_reset_prescale: assert property (@(posedge clock)
    rst |=> prescale_reg == 4'h0) else $error("reset left prescaler"); // R7
  chk_rise16_count: assert property (@(posedge clock) disable iff (rst)
    unit_mode_field == `MODE_RISE16 && capture_fire |-> prescale_reg == 4'hF) else $error("rise16 early"); // R2
  chk_irq_level: assert property (@(posedge clock) disable iff (rst)
    capture_event_flag_reg && capture_irq_enable_reg |=> irq) else $error("irq missing"); // R3
  cov_capture_rise4: cover property (@(posedge clock) unit_mode_field == `MODE_RISE4 && capture_fire);
  cov_capture_fall: cover property (@(posedge clock) unit_mode_field == `MODE_FALL && capture_fire);
  cov_set_clear: cover property (@(posedge clock) capture_fire && flag_clear);
endmodule

// ==== pin_source.sv ====
// far-side model of whatever drives the capture pin
`timescale 1ns/1ps
module pin_source
(
  input  wire logic clock,   // system clock
  input  wire logic pin_out, // unit latch level
  input  wire logic pin_oe,  // unit drives the pin
  output logic      pin_in   // resolved pin level
);
  logic drive_level; // level from the outside world

  // the unit wins while it drives; the detector takes the latch inside the unit, not pin_in
  assign pin_in = pin_oe ? pin_out : drive_level;
  initial drive_level = 1'b0;

  // hold each level long enough for sync, capture and flag to land
  task automatic set_level(input logic v);
    @(posedge clock);
    drive_level <= v;
    repeat (8) @(posedge clock);
  endtask

  // n full pulses, each giving one rising edge
  task automatic pulses(input int n);
    repeat (n)
    begin
      set_level(1'b1);
      set_level(1'b0);
    end
  endtask
endmodule

// ==== tb_input_capture_unit.sv ====
// self-checking bench for the input capture unit
`timescale 1ns/1ps
`include "capture_defs.svh"
`define CHK(n, e, g) \
  begin checks++; if ((g) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_input_capture_unit;
  logic        clock, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [15:0] time_base;
  logic        pin_in, pin_out, pin_oe, irq, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          n_errors, checks;

  input_capture_unit input_capture_unit_inst (.clock, .rst, .time_base, .pin_in, .pin_out, .pin_oe, .irq,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  pin_source pin_source_inst (.clock, .pin_out, .pin_oe, .pin_in);

  // 100 MHz system clock
  always #5 clock = ~clock;

  // write: offer address and data together, release each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", 2'h0, bresp)
  endtask

  // read one word and compare it
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata;
    rready <= 1'b0;
    `CHK(n, e, rv)
    `CHK("rresp", 2'h0, rresp)
  endtask

  // new mode: off first, then mode, then a clean flag
  task automatic set_mode(input logic [3:0] m);
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_CONTROL, {28'h0, m});
    wr(`OFS_FLAG_CLEAR, 32'h1);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // watchdog well beyond the expected thousand or so cycles
  initial
  begin
    repeat (40000) @(posedge clock);
    n_errors++;
    summarize();
  end

  initial
  begin
    {clock, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    time_base = 16'h0;
    rst = 1'b1;
    n_errors = 0;
    checks = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rc(`OFS_CONTROL, 32'h0, "control");
    rc(`OFS_PIN_CONTROL, 32'h1, "pin control");
    rc(8'h1C, 32'h0, "unmapped");
    // a write with no byte lane enabled must leave the register alone
    wstrb <= 4'h0;
    wr(`OFS_CONTROL, {28'h0, `MODE_RISE});
    wstrb <= 4'hF;
    rc(`OFS_CONTROL, 32'h0, "no strobe");
    wr(`OFS_FLAG_ENABLE, 32'h1);
    // every rising edge, then overwrite and sticky flag
    set_mode(`MODE_RISE);
    time_base <= 16'hA5C3;
    pin_source_inst.pulses(1);
    rc(`OFS_CAPTURE_LOW, 32'hC3, "cap low");
    rc(`OFS_CAPTURE_HIGH, 32'hA5, "cap high");
    `CHK("irq", 1'b1, irq)
    time_base <= 16'h1234;
    pin_source_inst.pulses(1);
    rc(`OFS_CAPTURE_LOW, 32'h34, "overwrite");
    rc(`OFS_FLAG_STATUS, 32'h1, "sticky");
    wr(`OFS_FLAG_ENABLE, 32'h0);
    @(posedge clock);
    `CHK("masked irq", 1'b0, irq)
    wr(`OFS_FLAG_CLEAR, 32'h1);
    rc(`OFS_FLAG_STATUS, 32'h0, "cleared");
    wr(`OFS_FLAG_ENABLE, 32'h1);
    // falling edge mode ignores the rising edge
    set_mode(`MODE_FALL);
    time_base <= 16'hBEEF;
    pin_source_inst.set_level(1'b1);
    rc(`OFS_FLAG_STATUS, 32'h0, "no rise");
    pin_source_inst.set_level(1'b0);
    rc(`OFS_CAPTURE_HIGH, 32'hBE, "fall cap");
    // prescaled modes capture on the 4th and 16th edge only
    for (int i = 0; i < 2; i++)
    begin
      set_mode(i ? `MODE_RISE16 : `MODE_RISE4);
      time_base <= 16'h0F00 + 16'(i);
      pin_source_inst.pulses(i ? 15 : 3);
      rc(`OFS_FLAG_STATUS, 32'h0, "early");
      pin_source_inst.pulses(1);
      rc(`OFS_FLAG_STATUS, 32'h1, "prescaled");
      rc(`OFS_CAPTURE_LOW, 32'(i), "prescaled low");
    end
    // switching 4 to 16 keeps the count: two plus fourteen edges
    set_mode(`MODE_RISE4);
    pin_source_inst.pulses(2);
    wr(`OFS_CONTROL, {28'h0, `MODE_RISE16});
    wr(`OFS_FLAG_CLEAR, 32'h1);
    pin_source_inst.pulses(13);
    rc(`OFS_FLAG_STATUS, 32'h0, "kept early");
    pin_source_inst.pulses(1);
    rc(`OFS_FLAG_STATUS, 32'h1, "kept count");
    // turning off in between clears the count
    set_mode(`MODE_RISE4);
    pin_source_inst.pulses(2);
    set_mode(`MODE_RISE4);
    pin_source_inst.pulses(3);
    rc(`OFS_FLAG_STATUS, 32'h0, "cleared count");
    pin_source_inst.pulses(1);
    rc(`OFS_FLAG_STATUS, 32'h1, "fresh count");
    // non-capture code: no flag, value kept
    set_mode(4'hA);
    time_base <= 16'h7777;
    pin_source_inst.pulses(1);
    rc(`OFS_FLAG_STATUS, 32'h0, "other mode");
    rc(`OFS_CAPTURE_LOW, 32'h01, "other keep");
    // pin as output: a latch write makes the edge
    set_mode(`MODE_RISE);
    wr(`OFS_PIN_CONTROL, 32'h0);
    `CHK("pin_oe", 1'b1, pin_oe)
    time_base <= 16'h4321;
    wr(`OFS_PIN_CONTROL, 32'h2);
    `CHK("pin_out", 1'b1, pin_out)
    repeat (8) @(posedge clock);
    rc(`OFS_CAPTURE_LOW, 32'h21, "latch cap");
    `CHK("irq latch", 1'b1, irq)
    summarize();
  end
endmodule
